// ===== hdl/scf_top.sv
// Functional notes
// - Tx irq from empty or complete, each enabled
// - Rx irq from full or quiet, each enabled
// - Enable rising sends preamble of ones
// - Disable finishes character then idles high
// - Re-enable mid character queues idle character
// - Enable writes ignored while module disabled
// - Rx disable stops receiver, flags kept
// - Standby masks rx irq, wake clears it
// - Break then clear ends with one bit
// - Held break repeats breaks back to back
// - Ninth rx bit latched with data
// - Ninth tx bit loaded with data
// - Error irq from four enabled error flags
// - Empty sets on transfer, clears by sequence
// - Complete while empty and nothing sending
// - Full sets on receive, clears by sequence
// - Quiet sets after frame of ones
// - Quiet needs a full character first
// - Overrun discards new, keeps old data
// - Overrun clears only if seen at status
// - Module disable forces empty, complete flags
// - Wake method picks idle or address mark
//
// Local design decisions: the AXI4-Lite register port and the address map.
`default_nettype none
module scf_top
  import scf_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rx_pin,
  output var  logic              tx_pin,
  output var  logic              tx_irq,
  output var  logic              rx_irq,
  output var  logic              err_irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]        ctl1_r;
  scf_ctl2_s         ctl2_r;
  scf_ctl3_s         ctl3_r;
  scf_stat1_s        stat_r;
  scf_stat1_s        seen_r;
  logic [7:0]        tx_buf_r;
  logic [7:0]        rx_buf_r;
  logic              rx_ninth_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wdata_r;
  logic              wstrb0_r;
  logic              aw_have_r;
  logic              w_have_r;

  logic              me;
  logic              nine;
  logic [3:0]        flen;
  logic              wr_fire;
  logic              ar_fire;
  logic              wr_hit;
  logic [7:0]        rd_mux;
  logic              rd_ok;

  assign me   = ctl1_r[CTL1_ME_BIT];
  assign nine = ctl1_r[CTL1_NINE_BIT];
  assign flen = nine ? FRAME_LEN_9 : FRAME_LEN_8;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign wr_hit  = wr_fire && wstrb0_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= 8'h00;
      wstrb0_r      <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_r      <= s_axi_awaddr;
        aw_have_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_r      <= s_axi_wdata[7:0];
        wstrb0_r     <= s_axi_wstrb[0];
        w_have_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == OFF_CTL1 || awaddr_r == OFF_CTL2 ||
                         awaddr_r == OFF_CTL3 || awaddr_r == OFF_STAT1 ||
                         awaddr_r == OFF_DATA) ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_comb
  begin
    rd_ok  = 1'b1;
    rd_mux = 8'h00;
    case (s_axi_araddr)
      OFF_CTL1:  rd_mux = ctl1_r;
      OFF_CTL2:  rd_mux = ctl2_r;
      OFF_CTL3:  rd_mux = {rx_ninth_r, ctl3_r.tx_ninth_bit, 2'b00,
                           ctl3_r[3:0]};
      OFF_STAT1: rd_mux = stat_r;
      OFF_DATA:  rd_mux = rx_buf_r;
      default:   rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_mux};
        s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  logic stat_rd;
  logic data_rd;
  logic data_wr;
  assign stat_rd = ar_fire && s_axi_araddr == OFF_STAT1;
  assign data_rd = ar_fire && s_axi_araddr == OFF_DATA;
  assign data_wr = wr_hit && awaddr_r == OFF_DATA;

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  scf_tx_e          tx_st_r;
  logic [CNT_W-1:0] tx_cyc_r;
  logic [3:0]       tx_bits_r;
  logic [10:0]      tx_sr_r;
  logic             te_prev_r;
  logic             pre_pend_r;
  logic             te;
  logic             te_rise;
  logic             tx_bit_end;
  logic             tx_last;
  logic             go_brk;
  logic             go_pre;
  logic             go_data;

  assign te         = ctl2_r.tx_enable && me;
  assign te_rise    = te && !te_prev_r;
  assign tx_bit_end = tx_cyc_r == CNT_W'(BIT_CYCLES - 1);
  assign tx_last    = tx_bits_r == flen - 4'h1;

  always_comb
  begin
    go_brk  = 1'b0;
    go_pre  = 1'b0;
    go_data = 1'b0;
    if (tx_st_r == TX_IDLE && te)
    begin
      if (ctl2_r.break_send_ctl)
        go_brk = 1'b1;
      else if (pre_pend_r)
        go_pre = 1'b1;
      else if (!stat_r.tx_buf_empty_flag)
        go_data = 1'b1;
    end
  end

  // Preamble request survives a busy frame, so re-enable queues it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      te_prev_r  <= 1'b0;
      pre_pend_r <= 1'b0;
    end
    else if (ce)
    begin
      te_prev_r  <= te;
      pre_pend_r <= te_rise || (pre_pend_r && !go_pre && !go_brk);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_st_r   <= TX_IDLE;
      tx_cyc_r  <= '0;
      tx_bits_r <= 4'h0;
      tx_sr_r   <= 11'h7ff;
      tx_pin    <= 1'b1;
    end
    else if (ce)
    begin
      tx_cyc_r <= tx_bit_end ? '0 : tx_cyc_r + CNT_W'(1);
      case (tx_st_r)
        TX_IDLE:
        begin
          tx_cyc_r  <= '0;
          tx_bits_r <= 4'h0;
          tx_pin    <= 1'b1;
          if (go_brk)
          begin
            tx_st_r <= TX_BRK;
            tx_pin  <= 1'b0;
          end
          else if (go_pre)
            tx_st_r <= TX_PRE;
          else if (go_data)
          begin
            tx_st_r <= TX_DATA;
            tx_sr_r <= {1'b1, nine ? ctl3_r.tx_ninth_bit : 1'b1,
                        tx_buf_r, 1'b0};
            tx_pin  <= 1'b0;
          end
        end
        TX_DATA:
          if (tx_bit_end)
          begin
            tx_bits_r <= tx_bits_r + 4'h1;
            tx_sr_r   <= {1'b1, tx_sr_r[10:1]};
            tx_pin    <= tx_last ? 1'b1 : tx_sr_r[1];
            if (tx_last)
              tx_st_r <= TX_IDLE;
          end
        TX_PRE:
          if (tx_bit_end)
          begin
            tx_bits_r <= tx_bits_r + 4'h1;
            if (tx_last)
              tx_st_r <= TX_IDLE;
          end
        TX_BRK:
          if (tx_bit_end)
          begin
            tx_bits_r <= tx_bits_r + 4'h1;
            if (tx_last)
            begin
              tx_bits_r <= 4'h0;
              if (!(ctl2_r.break_send_ctl && te))
              begin
                tx_st_r <= TX_ONE;
                tx_pin  <= 1'b1;
              end
            end
          end
        TX_ONE:
          if (tx_bit_end)
            tx_st_r <= TX_IDLE;
        default:
          tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  scf_rx_e          rx_st_r;
  logic [CNT_W-1:0] rx_cyc_r;
  logic [CNT_W-1:0] quiet_cyc_r;
  logic [3:0]       rx_bits_r;
  logic [9:0]       rx_sr_r;
  logic             re_prev_r;
  logic             quiet_arm_r;
  logic             rx_s;
  logic             re;
  logic             rx_done;
  logic             rx_false;
  logic [9:0]       rx_word;
  logic [7:0]       rx_data;
  logic             rx_b8;
  logic             rx_stop;
  logic             rx_msb;
  logic             rx_perr;
  logic             accept;
  logic             quiet_evt;
  logic [CNT_W-1:0] quiet_lim;

  scf_sync #(
    .RST_VAL (RX_IDLE_LVL)
  ) u_rx_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (rx_pin),
    .q       (rx_s)
  );

  assign re       = ctl2_r.rx_enable && me;
  assign rx_word  = {rx_s, rx_sr_r[9:1]};
  assign rx_data  = nine ? rx_word[7:0] : rx_word[8:1];
  assign rx_b8    = rx_word[8];
  assign rx_stop  = rx_word[9];
  assign rx_msb   = nine ? rx_b8 : rx_data[7];
  assign rx_perr  = ctl1_r[CTL1_PEN_BIT] &&
                    ((nine ? ^rx_word[8:0] : ^rx_word[8:1]) !=
                     ctl1_r[CTL1_PODD_BIT]);
  assign rx_done  = rx_st_r == RX_BITS && rx_cyc_r == CNT_W'(BIT_CYCLES - 1)
                    && rx_bits_r == flen - 4'h2;
  assign rx_false = rx_st_r == RX_START && re &&
                    rx_cyc_r == CNT_W'(BIT_CYCLES / 2) && rx_s;
  // Standby drops characters, except an address-mark waking one
  assign accept   = rx_done && (!ctl2_r.rx_standby_ctl ||
                    (ctl1_r[CTL1_WAKE_BIT] && rx_msb));
  assign quiet_lim = CNT_W'(int'(flen) * BIT_CYCLES);
  assign quiet_evt = quiet_cyc_r == quiet_lim - CNT_W'(1) && rx_s &&
                     re && rx_st_r == RX_IDLE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_st_r     <= RX_IDLE;
      rx_cyc_r    <= '0;
      rx_bits_r   <= 4'h0;
      rx_sr_r     <= 10'h3ff;
      quiet_cyc_r <= '0;
    end
    else if (ce)
    begin
      if (rx_st_r == RX_IDLE && rx_s && re)
      begin
        if (quiet_cyc_r != quiet_lim)
          quiet_cyc_r <= quiet_cyc_r + CNT_W'(1);
      end
      else
        quiet_cyc_r <= '0;
      rx_cyc_r <= rx_cyc_r + CNT_W'(1);
      case (rx_st_r)
        RX_IDLE:
        begin
          rx_cyc_r  <= '0;
          rx_bits_r <= 4'h0;
          if (re && !rx_s)
            rx_st_r <= RX_START;
        end
        RX_START:
          if (rx_cyc_r == CNT_W'(BIT_CYCLES / 2))
          begin
            rx_cyc_r <= '0;
            rx_st_r  <= rx_s ? RX_IDLE : RX_BITS;
          end
        RX_BITS:
          if (rx_cyc_r == CNT_W'(BIT_CYCLES - 1))
          begin
            rx_cyc_r  <= '0;
            rx_sr_r   <= rx_word;
            rx_bits_r <= rx_bits_r + 4'h1;
            if (rx_done)
              rx_st_r <= RX_IDLE;
          end
        default:
          rx_st_r <= RX_IDLE;
      endcase
      if (!re)
        rx_st_r <= RX_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl1_r   <= CTL1_RST;
      ctl2_r   <= CTL2_RST;
      ctl3_r   <= CTL3_RST;
      tx_buf_r <= 8'h00;
    end
    else if (ce)
    begin
      if ((quiet_evt && !ctl1_r[CTL1_WAKE_BIT]) ||
          (rx_done && ctl1_r[CTL1_WAKE_BIT] && rx_msb))
        ctl2_r.rx_standby_ctl <= 1'b0;
      if (wr_hit)
        case (awaddr_r)
          OFF_CTL1: ctl1_r <= wdata_r;
          OFF_CTL2:
          begin
            ctl2_r <= wdata_r;
            if (!me)
            begin
              ctl2_r.tx_enable <= ctl2_r.tx_enable;
              ctl2_r.rx_enable <= ctl2_r.rx_enable;
            end
          end
          OFF_CTL3: ctl3_r <= {1'b0, wdata_r[6], 2'b00, wdata_r[3:0]};
          OFF_DATA: tx_buf_r <= wdata_r;
          default: ;
        endcase
    end
  end

  // ----------------------------------------------------------------
  // Status flags, set wins over clear
  // ----------------------------------------------------------------
  logic rd_clr;
  assign rd_clr = data_rd;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_r      <= STAT1_RST;
      seen_r      <= 8'h00;
      rx_buf_r    <= 8'h00;
      rx_ninth_r  <= 1'b0;
      re_prev_r   <= 1'b0;
      quiet_arm_r <= 1'b0;
    end
    else if (ce)
    begin
      re_prev_r <= re;
      if (stat_rd)
        seen_r <= stat_r;
      else
      begin
        if (data_wr)
          seen_r.tx_buf_empty_flag <= 1'b0;
        if (rd_clr)
          seen_r[5:0] <= 6'h00;
      end
      if (!me || go_data)
        stat_r.tx_buf_empty_flag <= 1'b1;
      else if (data_wr && seen_r.tx_buf_empty_flag)
        stat_r.tx_buf_empty_flag <= 1'b0;
      stat_r.tx_complete_flag <= !me || (stat_r.tx_buf_empty_flag &&
        tx_st_r == TX_IDLE && !(te && (pre_pend_r ||
        ctl2_r.break_send_ctl)) && !go_data);
      if (accept && !stat_r.rx_full_flag)
      begin
        stat_r.rx_full_flag  <= 1'b1;
        rx_buf_r             <= rx_data;
        rx_ninth_r           <= nine ? rx_b8 : rx_data[7];
        quiet_arm_r          <= 1'b1;
      end
      else if (rd_clr && seen_r.rx_full_flag)
        stat_r.rx_full_flag  <= 1'b0;
      if (quiet_evt && quiet_arm_r)
      begin
        stat_r.rx_quiet_flag <= 1'b1;
        quiet_arm_r          <= 1'b0;
      end
      else if (rd_clr && seen_r.rx_quiet_flag)
        stat_r.rx_quiet_flag <= 1'b0;
      if (re && !re_prev_r)
        quiet_arm_r <= 1'b0;
      if (accept && stat_r.rx_full_flag)
        stat_r.rx_overrun_flag <= 1'b1;
      else if (rd_clr && seen_r.rx_overrun_flag)
        stat_r.rx_overrun_flag <= 1'b0;
      if (rx_false)
        stat_r.rx_noise_flag <= 1'b1;
      else if (rd_clr && seen_r.rx_noise_flag)
        stat_r.rx_noise_flag <= 1'b0;
      if (accept && !stat_r.rx_full_flag && !rx_stop)
        stat_r.rx_framing_err_flag <= 1'b1;
      else if (rd_clr && seen_r.rx_framing_err_flag)
        stat_r.rx_framing_err_flag <= 1'b0;
      if (accept && !stat_r.rx_full_flag && rx_perr)
        stat_r.rx_parity_error_flag <= 1'b1;
      else if (rd_clr && seen_r.rx_parity_error_flag)
        stat_r.rx_parity_error_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_irq  <= 1'b0;
      rx_irq  <= 1'b0;
      err_irq <= 1'b0;
    end
    else if (ce)
    begin
      tx_irq  <= me &&
        ((stat_r.tx_buf_empty_flag && ctl2_r.txempty_irq_en) ||
         (stat_r.tx_complete_flag && ctl2_r.done_irq_en));
      rx_irq  <= !ctl2_r.rx_standby_ctl &&
        ((stat_r.rx_full_flag && ctl2_r.rxfull_irq_en) ||
         (stat_r.rx_quiet_flag && ctl2_r.quiet_irq_en));
      err_irq <=
        (stat_r.rx_overrun_flag && ctl3_r.overrun_irq_en) ||
        (stat_r.rx_noise_flag && ctl3_r.noise_irq_en) ||
        (stat_r.rx_framing_err_flag && ctl3_r.framing_irq_en) ||
        (stat_r.rx_parity_error_flag && ctl3_r.parity_irq_en);
    end
  end
endmodule
`default_nettype wire

// ===== hdl/scf_pkg.sv
`default_nettype none
package scf_pkg;
  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam int           ADDR_W       = 8;
  localparam logic [7:0]   OFF_CTL1     = 8'h00;
  localparam logic [7:0]   OFF_CTL2     = 8'h04;
  localparam logic [7:0]   OFF_CTL3     = 8'h08;
  localparam logic [7:0]   OFF_STAT1    = 8'h0c;
  localparam logic [7:0]   OFF_DATA     = 8'h10;

  localparam logic [1:0]   RESP_OKAY    = 2'h0;
  localparam logic [1:0]   RESP_DECERR  = 2'h3;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int           CTL1_ME_BIT   = 6;
  localparam int           CTL1_NINE_BIT = 4;
  localparam int           CTL1_WAKE_BIT = 3;
  localparam int           CTL1_PEN_BIT  = 1;
  localparam int           CTL1_PODD_BIT = 0;

  localparam logic [7:0]   CTL1_RST     = 8'h00;
  localparam logic [7:0]   CTL2_RST     = 8'h00;
  localparam logic [7:0]   CTL3_RST     = 8'h00;
  localparam logic [7:0]   STAT1_RST    = 8'hc0;
  localparam logic         RX_IDLE_LVL  = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int           CLK_PERIOD_NS  = 5;
  localparam int           BIT_CYCLES_DEF = 16;
  localparam int           CNT_W          = 12;
  localparam logic [3:0]   FRAME_LEN_8    = 4'ha;
  localparam logic [3:0]   FRAME_LEN_9    = 4'hb;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic txempty_irq_en;
    logic done_irq_en;
    logic rxfull_irq_en;
    logic quiet_irq_en;
    logic tx_enable;
    logic rx_enable;
    logic rx_standby_ctl;
    logic break_send_ctl;
  } scf_ctl2_s;

  typedef struct packed {
    logic       rx_ninth_bit;
    logic       tx_ninth_bit;
    logic [1:0] rsvd;
    logic       overrun_irq_en;
    logic       noise_irq_en;
    logic       framing_irq_en;
    logic       parity_irq_en;
  } scf_ctl3_s;

  typedef struct packed {
    logic tx_buf_empty_flag;
    logic tx_complete_flag;
    logic rx_full_flag;
    logic rx_quiet_flag;
    logic rx_overrun_flag;
    logic rx_noise_flag;
    logic rx_framing_err_flag;
    logic rx_parity_error_flag;
  } scf_stat1_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_PRE  = 3'h1,
    TX_DATA = 3'h3,
    TX_BRK  = 3'h2,
    TX_ONE  = 3'h6
  } scf_tx_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_BITS  = 2'h3
  } scf_rx_e;
endpackage
`default_nettype wire

// ===== hdl/scf_sync.sv
`default_nettype none
module scf_sync
  import scf_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
)(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic d,
  output var  logic q
);
  logic meta_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end
    else if (ce)
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== tb/scf_sva.sv
`default_nettype none
module scf_sva #(
  parameter int BIT_CYCLES = 16
)(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        tx_pin,
  input wire logic        tx_irq,
  input wire logic        rx_irq,
  input wire logic        err_irq
);
  logic        last_r;
  logic [15:0] run_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // Low run length, every low stretch is whole bits
  // ----
  always_ff @(posedge aclk)
  begin
    last_r <= aresetn ? tx_pin : 1'b1;
    run_r  <= (tx_pin != last_r) ? 16'h1 : run_r + 16'h1;
  end
  property p_rst;
    disable iff (1'b0) !aresetn |=> tx_pin && !tx_irq && !rx_irq && !err_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  property p_run; tx_pin && !last_r |-> run_r % BIT_CYCLES == 0; endproperty
  a_run: assert property (p_run) else $error("low run length");
  property p_byte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_byte: assert property (p_byte) else $error("upper read data");
  property p_wans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_wans: assert property (p_wans) else $error("write answer late");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy: assert property (p_busy) else $error("ready during response");
  property p_wdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  a_wdone: assert property (p_wdone) else $error("write not closed");
  property p_rdone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_rdone: assert property (p_rdone) else $error("read not closed");
endmodule
`default_nettype wire

// ===== tb/scf_node.sv
`default_nettype none
module scf_node #(
  parameter int BIT = 4
)(
  input  wire logic aclk,
  input  wire logic tx_pin,
  output var  logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Remote node, line idles high between frames
  // ----
  initial rx_pin = 1'b1;
  // Start low, LSB first, then highs as stop and rest
  task automatic send(input logic [8:0] d);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rx_pin <= f[i];
      repeat (BIT) @(posedge aclk);
    end
  endtask
  // Mid-bit sampling tolerates small phase error
  task automatic grab(output logic [7:0] d);
    while (tx_pin) @(posedge aclk);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT) @(posedge aclk);
      if (i < 8) d[i] = tx_pin;
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/scf_top_tb.sv
`default_nettype none
module scf_top_tb
  import scf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BC = 4;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b1;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        rx_pin, tx_pin, tx_irq, rx_irq, err_irq;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          n;
  logic [7:0]  rd;
  always #2.5 aclk = ~aclk;
  scf_top #(.BIT_CYCLES(BC)) DUT (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_pin,
    .tx_pin, .tx_irq, .rx_irq, .err_irq);
  scf_node #(.BIT(BC)) node (.aclk, .tx_pin, .rx_pin);
  // ----
  // Bus tasks and compare
  // ----
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    bit aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (!aw && s_axi_awready)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready)
      begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    chk("bresp", {6'h0, er}, {6'h0, s_axi_bresp});
  endtask
  task automatic rdr(input logic [7:0] a, output logic [7:0] d,
                     input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    chk("rresp", {6'h0, er}, {6'h0, s_axi_rresp});
  endtask
  task automatic rc(input logic [7:0] a, e, m, input string nm);
    rdr(a, rd, RESP_OKAY);
    chk(nm, e, rd & m);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(OFF_CTL1, CTL1_RST, 8'hff, "ctl1");
    rc(OFF_CTL2, CTL2_RST, 8'hff, "ctl2");
    rc(OFF_CTL3, CTL3_RST, 8'hff, "ctl3");
    rc(OFF_STAT1, STAT1_RST, 8'hff, "stat1");
    rdr(8'h14, rd, RESP_DECERR);
    chk("unmapped", 8'h00, rd);
    wr(8'h14, 8'hff, RESP_DECERR);
    wr(OFF_CTL2, 8'h0c, RESP_OKAY);
    rc(OFF_CTL2, 8'h00, 8'hff, "locked ctl2");
    wr(OFF_CTL1, 8'h40, RESP_OKAY);
    wr(OFF_CTL2, 8'hac, RESP_OKAY);
    @(posedge aclk);
    rc(OFF_STAT1, 8'h80, 8'hff, "preamble");
    chk("tx irq", 8'h01, {7'h0, tx_irq});
    wr(OFF_DATA, 8'ha5, RESP_OKAY);
    rc(OFF_STAT1, 8'h00, 8'hff, "empty clr");
    node.grab(rd);
    chk("tx byte", 8'ha5, rd);
    repeat (2 * BC) @(posedge aclk);
    rc(OFF_STAT1, 8'hc0, 8'hff, "tx done");
    node.send(9'h1c3);
    repeat (14 * BC) @(posedge aclk);
    chk("rx irq", 8'h01, {7'h0, rx_irq});
    rc(OFF_STAT1, 8'hf0, 8'hff, "full quiet");
    rc(OFF_CTL3, 8'h80, 8'h80, "ninth");
    rc(OFF_DATA, 8'hc3, 8'hff, "rx data");
    repeat (14 * BC) @(posedge aclk);
    rc(OFF_STAT1, 8'hc0, 8'hff, "no rearm");
    wr(OFF_CTL3, 8'h08, RESP_OKAY);
    node.send(9'h111);
    node.send(9'h122);
    repeat (4 * BC) @(posedge aclk);
    chk("err irq", 8'h01, {7'h0, err_irq});
    rc(OFF_STAT1, 8'he8, 8'hef, "overrun");
    rc(OFF_DATA, 8'h11, 8'hff, "kept");
    node.send(9'h133);
    rc(OFF_STAT1, 8'he0, 8'hef, "full");
    node.send(9'h144);
    rc(OFF_DATA, 8'h33, 8'hff, "kept2");
    rc(OFF_STAT1, 8'hc8, 8'hef, "or kept");
    wr(OFF_CTL2, 8'h0e, RESP_OKAY);
    repeat (14 * BC) @(posedge aclk);
    rc(OFF_CTL2, 8'h0c, 8'hff, "wake idle");
    wr(OFF_CTL2, 8'h8d, RESP_OKAY);
    n = 0;
    fork
      wr(OFF_CTL2, 8'h8c, RESP_OKAY);
      begin
        while (tx_pin) @(posedge aclk);
        while (!tx_pin)
        begin
          @(posedge aclk);
          n++;
        end
      end
    join
    chk("break len", 8'(10 * BC), 8'(n));
    wr(OFF_CTL1, 8'h00, RESP_OKAY);
    rc(OFF_STAT1, 8'hc0, 8'hc0, "disabled");
    chk("tx irq off", 8'h00, {7'h0, tx_irq});
    finish_test();
  end
endmodule
bind scf_top scf_sva #(.BIT_CYCLES(BIT_CYCLES)) u_sva (.aclk, .aresetn,
  .s_axi_awready, .s_axi_awvalid, .s_axi_wready, .s_axi_wvalid,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .tx_pin, .tx_irq, .rx_irq,
  .err_irq);
`default_nettype wire
